// file: hdl/tss_pkg.sv
package tss_pkg;
  localparam int         CLK_NS              = 10;
  localparam int         BUS_TIMEOUT_TIME_US = 30;
  localparam int         BUS_TIMEOUT_TIME_CYC            = BUS_TIMEOUT_TIME_US * 1000 / CLK_NS;
  localparam int         SCL_PERIOD_NS       = 4000;
  localparam int         SCL_QTR_CYC         = SCL_PERIOD_NS / 4 / CLK_NS;
  localparam logic [3:0] DEV_PREFIX          = 4'h3;
  localparam logic [3:0] PTR_CAP             = 4'h0;
  localparam logic [3:0] PTR_CFG             = 4'h1;
  localparam logic [3:0] PTR_UP              = 4'h2;
  localparam logic [3:0] PTR_LO              = 4'h3;
  localparam logic [3:0] PTR_CRIT            = 4'h4;
  localparam logic [3:0] PTR_AMB             = 4'h5;
  localparam logic [3:0] PTR_MAKER           = 4'h6;
  localparam logic [3:0] PTR_PART            = 4'h7;
  localparam logic [3:0] PTR_RES             = 4'h8;
  localparam int         CFG_HYST            = 9;
  localparam int         CFG_SHDN            = 8;
  localparam int         CFG_CLOCK           = 7;
  localparam int         CFG_WLOCK           = 6;
  localparam int         CFG_ESTAT           = 4;
  localparam int         CFG_ECNT            = 3;
  localparam int         CFG_ESEL            = 2;
  localparam int         CFG_EPOL            = 1;
  localparam int         CFG_EMOD            = 0;
  localparam logic [15:0] LIM_MASK           = 16'h1ffc;
  localparam logic [2:0] CAP_FLAGS           = 3'h7;
  localparam logic [1:0] RES_RESET           = 2'h1;
  localparam logic [7:0] HR_CMD              = 8'h00;
  localparam logic [7:0] HR_WDATA            = 8'h04;
  localparam logic [7:0] HR_STAT             = 8'h08;
  localparam logic [7:0] HR_RDATA            = 8'h0c;
  localparam int         CMD_PTR_LSB         = 0;
  localparam int         CMD_ASEL_LSB        = 4;
  localparam int         CMD_MODE_LSB        = 8;
  localparam logic [1:0] MODE_PTR            = 2'h0;
  localparam logic [1:0] MODE_WR             = 2'h1;
  localparam logic [1:0] MODE_RD             = 2'h2;
endpackage

// file: hdl/tss_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tss_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Open-drain wires with pull-ups: any enabled low driver wins.
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// file: hdl/tss_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tss_pin_sync (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] lvl,
  output logic      [1:0] rise,
  output logic      [1:0] fall
);
  logic [1:0] meta_ff;
  logic [1:0] lvl_ff;
  logic [1:0] old_ff;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_ff <= 2'h3;
      lvl_ff  <= 2'h3;
      old_ff  <= 2'h3;
    end else begin
      meta_ff <= pin_in;
      lvl_ff  <= meta_ff;
      old_ff  <= lvl_ff;
    end
  end

  assign lvl  = lvl_ff;
  assign rise = lvl_ff & ~old_ff;
  assign fall = ~lvl_ff & old_ff;
endmodule
`default_nettype wire

// file: hdl/tss_slave.sv
// Added by the designer: register access over the two-wire serial bus.
`timescale 1ns/1ps
`default_nettype none
module tss_slave
  import tss_pkg::*;
#(
  // fixed id words; the values are arbitrary.
  parameter logic [15:0] MAKER_CODE = 16'h0a5a,
  parameter logic [15:0] PART_CODE  = 16'h0b01
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  tss_if.slave             bus,
  input  wire logic        addr_select_hi,
  input  wire logic        addr_select_mid,
  input  wire logic        addr_select_lo,
  input  wire logic        conv_done,
  input  wire logic [12:0] temp_sample,
  output logic             event_out,
  output logic             shutdown
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_RX   = 7'h08,
    S_WACK = 7'h10,
    S_TX   = 7'h20,
    S_RACK = 7'h40
  } tss_sst_e;

  tss_sst_e    st_ff;
  tss_sst_e    nxt_st;
  logic [1:0]  lvl;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [2:0]  asel_m_ff;
  logic [2:0]  asel_ff;
  logic [7:0]  sh_ff;
  logic [7:0]  nxt_sh;
  logic [3:0]  bit_ff;
  logic [3:0]  nxt_bit;
  logic [1:0]  byte_ff;
  logic [1:0]  nxt_byte;
  logic        rd_ff;
  logic        nxt_rd;
  logic        oe_ff;
  logic        nxt_oe;
  logic [15:0] bus_timeout_time_ff;
  logic [3:0]  ptr_ff;
  logic [7:0]  hi_ff;
  logic [15:0] cfg_ff;
  logic [15:0] cfg_w;
  logic [15:0] up_ff;
  logic [15:0] lo_ff;
  logic [15:0] crit_ff;
  logic [15:0] amb_ff;
  logic [1:0]  res_ff;
  logic        event_ff;
  logic [15:0] rd_word;

  tss_pin_sync u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pin_in ({bus.sda, bus.scl}),
    .lvl    (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  wire start_ev = fall[1] & lvl[0];
  wire stop_ev  = rise[1] & lvl[0];
  wire bus_timeout_time_hit = bus_timeout_time_ff == 16'(BUS_TIMEOUT_TIME_CYC - 1);
  wire addr_hit = sh_ff[7:1] == {DEV_PREFIX, asel_ff};
  wire byte_end = fall[0] && bit_ff == 4'h8;
  wire wr_ev    = (st_ff == S_RX) && byte_end;
  wire wr_ptr   = wr_ev && byte_ff == 2'h0;
  wire wr_hi    = wr_ev && byte_ff == 2'h1;
  wire wr_word  = wr_ev && byte_ff == 2'h2;
  wire [15:0] wdata = {hi_ff, sh_ff};
  wire any_lock = cfg_ff[CFG_CLOCK] | cfg_ff[CFG_WLOCK];
  wire [12:0] amb_t = amb_ff[12:0];
  wire gt_up = $signed(temp_sample) > $signed(up_ff[12:0]);
  wire lt_lo = $signed(temp_sample) < $signed(lo_ff[12:0]);
  wire ge_crit = $signed(temp_sample) >= $signed(crit_ff[12:0]);
  wire evt_cond = cfg_ff[CFG_ESEL] ? amb_ff[15] : |amb_ff[15:13];
  wire evt_act  = cfg_ff[CFG_ECNT] & evt_cond;
  wire [15:0] cfg_rd = cfg_ff | ({15'h0, evt_act} << CFG_ESTAT);
  wire [15:0] cap_word = {8'h00, 3'h0, res_ff, CAP_FLAGS};

  assign rd_word = (ptr_ff == PTR_CAP)   ? cap_word :
                   (ptr_ff == PTR_CFG)   ? cfg_rd :
                   (ptr_ff == PTR_UP)    ? up_ff :
                   (ptr_ff == PTR_LO)    ? lo_ff :
                   (ptr_ff == PTR_CRIT)  ? crit_ff :
                   (ptr_ff == PTR_AMB)   ? {amb_ff[15:13], amb_t} :
                   (ptr_ff == PTR_MAKER) ? MAKER_CODE :
                   (ptr_ff == PTR_PART)  ? PART_CODE :
                   (ptr_ff == PTR_RES)   ? {14'h0, res_ff} : 16'h0000;

  wire [7:0] tx_byte = (ptr_ff == PTR_RES || byte_ff[0]) ? rd_word[7:0] : rd_word[15:8];

  always_comb begin
    nxt_st   = st_ff;
    nxt_sh   = sh_ff;
    nxt_bit  = bit_ff;
    nxt_byte = byte_ff;
    nxt_rd   = rd_ff;
    nxt_oe   = oe_ff;
    if (start_ev) begin
      nxt_st  = S_ADDR;
      nxt_bit = 4'h0;
      nxt_oe  = 1'b0;
    end else if (stop_ev || bus_timeout_time_hit) begin
      nxt_st = S_IDLE;
      nxt_oe = 1'b0;
    end else begin
      case (st_ff)
        S_IDLE: begin
          nxt_oe = 1'b0;
        end
        S_ADDR, S_RX: begin
          if (rise[0] && bit_ff != 4'h8) begin
            nxt_sh  = {sh_ff[6:0], lvl[1]};
            nxt_bit = bit_ff + 4'h1;
          end else if (byte_end) begin
            nxt_bit = 4'h0;
            if (st_ff == S_RX) begin
              nxt_st = S_WACK;
              nxt_oe = 1'b1;
            end else if (addr_hit) begin
              nxt_st   = S_AACK;
              nxt_oe   = 1'b1;
              nxt_rd   = sh_ff[0];
              nxt_byte = 2'h0;
            end else begin
              nxt_st = S_IDLE;
            end
          end
        end
        S_AACK: begin
          if (fall[0]) begin
            if (rd_ff) begin
              nxt_st  = S_TX;
              nxt_oe  = ~tx_byte[7];
              nxt_sh  = {tx_byte[6:0], 1'b0};
              nxt_bit = 4'h1;
            end else begin
              nxt_st = S_RX;
              nxt_oe = 1'b0;
            end
          end
        end
        S_WACK: begin
          if (fall[0]) begin
            nxt_st   = S_RX;
            nxt_oe   = 1'b0;
            nxt_byte = (byte_ff == 2'h3) ? byte_ff : byte_ff + 2'h1;
          end
        end
        S_TX: begin
          if (fall[0]) begin
            if (bit_ff == 4'h8) begin
              nxt_st = S_RACK;
              nxt_oe = 1'b0;
            end else begin
              nxt_oe  = ~sh_ff[7];
              nxt_sh  = {sh_ff[6:0], 1'b0};
              nxt_bit = bit_ff + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (rise[0]) begin
            if (lvl[1]) begin
              nxt_st = S_IDLE;
            end else begin
              nxt_byte = byte_ff + 2'h1;
            end
          end else if (fall[0]) begin
            nxt_st  = S_TX;
            nxt_oe  = ~tx_byte[7];
            nxt_sh  = {tx_byte[6:0], 1'b0};
            nxt_bit = 4'h1;
          end
        end
        default: begin
          nxt_st = S_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  // Locks stick until reset; shutdown may still be cleared while locked.
  always_comb begin
    cfg_w = cfg_ff;
    cfg_w[CFG_CLOCK] = cfg_ff[CFG_CLOCK] | wdata[CFG_CLOCK];
    cfg_w[CFG_WLOCK] = cfg_ff[CFG_WLOCK] | wdata[CFG_WLOCK];
    cfg_w[CFG_SHDN]  = wdata[CFG_SHDN] & (~any_lock | cfg_ff[CFG_SHDN]);
    if (!any_lock) begin
      cfg_w[CFG_HYST +: 2] = wdata[CFG_HYST +: 2];
      cfg_w[CFG_ECNT]      = wdata[CFG_ECNT];
      cfg_w[CFG_EPOL]      = wdata[CFG_EPOL];
      cfg_w[CFG_EMOD]      = wdata[CFG_EMOD];
    end
    if (!cfg_ff[CFG_WLOCK]) begin
      cfg_w[CFG_ESEL] = wdata[CFG_ESEL];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff     <= S_IDLE;
      sh_ff     <= 8'h00;
      bit_ff    <= 4'h0;
      byte_ff   <= 2'h0;
      rd_ff     <= 1'b0;
      oe_ff     <= 1'b0;
      asel_m_ff <= 3'h0;
      asel_ff   <= 3'h0;
    end else begin
      st_ff     <= nxt_st;
      sh_ff     <= nxt_sh;
      bit_ff    <= nxt_bit;
      byte_ff   <= nxt_byte;
      rd_ff     <= nxt_rd;
      oe_ff     <= nxt_oe;
      asel_m_ff <= {addr_select_hi, addr_select_mid, addr_select_lo};
      asel_ff   <= asel_m_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || st_ff == S_IDLE || rise[0] || fall[0] || start_ev) begin
      bus_timeout_time_ff <= 16'h0000;
    end else begin
      bus_timeout_time_ff <= bus_timeout_time_ff + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ptr_ff  <= PTR_CAP;
      hi_ff   <= 8'h00;
      cfg_ff  <= 16'h0000;
      up_ff   <= 16'h0000;
      lo_ff   <= 16'h0000;
      crit_ff <= 16'h0000;
      res_ff  <= RES_RESET;
    end else begin
      if (wr_ptr) ptr_ff <= sh_ff[3:0];
      if (wr_hi) hi_ff <= sh_ff;
      if (wr_hi && ptr_ff == PTR_RES) res_ff <= sh_ff[1:0];
      if (wr_word && ptr_ff == PTR_CFG) cfg_ff <= cfg_w;
      if (wr_word && ptr_ff == PTR_UP && !cfg_ff[CFG_WLOCK]) up_ff <= wdata & LIM_MASK;
      if (wr_word && ptr_ff == PTR_LO && !cfg_ff[CFG_WLOCK]) lo_ff <= wdata & LIM_MASK;
      if (wr_word && ptr_ff == PTR_CRIT && !cfg_ff[CFG_CLOCK]) crit_ff <= wdata & LIM_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      amb_ff   <= 16'h0000;
      event_ff <= 1'b1;
    end else begin
      if (conv_done && !cfg_ff[CFG_SHDN]) amb_ff <= {ge_crit, gt_up, lt_lo, temp_sample};
      event_ff <= evt_act ~^ cfg_ff[CFG_EPOL];
    end
  end

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = oe_ff;
  assign event_out    = event_ff;
  assign shutdown     = cfg_ff[CFG_SHDN];
endmodule
`default_nettype wire

// file: hdl/tss_host.sv
`timescale 1ns/1ps
`default_nettype none
module tss_host
  import tss_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  tss_if.master            bus
);
  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_BIT   = 4'h4,
    M_STOP  = 4'h8
  } tss_mst_e;

  tss_mst_e    st_ff;
  logic [1:0]  lvl;
  logic        a_wr_ff;
  logic [7:0]  a_addr_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] cmd_ff;
  logic [15:0] wdat_ff;
  logic [15:0] rdat_ff;
  logic        nack_ff;
  logic [7:0]  qcnt_ff;
  logic [1:0]  ph_ff;
  logic [1:0]  bi_ff;
  logic [3:0]  bt_ff;
  logic        scl_oe_ff;
  logic        sda_oe_ff;

  tss_pin_sync u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pin_in ({bus.sda, bus.scl}),
    .lvl    (lvl),
    .rise   (),
    .fall   ()
  );

  wire        a_take = hsel & hready & htrans[1];
  wire        busy   = st_ff != M_IDLE;
  wire        go_cmd = a_wr_ff && a_addr_ff == HR_CMD && !busy;
  wire [1:0]  mode   = cmd_ff[CMD_MODE_LSB +: 2];
  wire        is_rd  = mode == MODE_RD;
  wire [1:0]  last_b = is_rd ? 2'h2 : (mode == MODE_WR) ? 2'h3 : 2'h1;
  wire        rx     = is_rd && bi_ff != 2'h0;
  wire        tick   = qcnt_ff == 8'(SCL_QTR_CYC - 1);
  wire        last   = bi_ff == last_b;
  wire [7:0]  cur_byte = (bi_ff == 2'h0) ? {DEV_PREFIX, cmd_ff[CMD_ASEL_LSB +: 3], is_rd} :
                         (bi_ff == 2'h1 && !is_rd) ? {4'h0, cmd_ff[CMD_PTR_LSB +: 4]} :
                         (bi_ff == 2'h2) ? wdat_ff[15:8] : wdat_ff[7:0];
  wire        tx_bit = cur_byte[3'(4'h7 - bt_ff)];
  wire [31:0] rd_mux = (haddr[7:0] == HR_CMD)   ? {16'h0, cmd_ff} :
                       (haddr[7:0] == HR_WDATA) ? {16'h0, wdat_ff} :
                       (haddr[7:0] == HR_STAT)  ? {30'h0, nack_ff, busy} :
                       (haddr[7:0] == HR_RDATA) ? {16'h0, rdat_ff} : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      a_wr_ff   <= 1'b0;
      a_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
    end else begin
      a_wr_ff   <= a_take & hwrite;
      a_addr_ff <= haddr[7:0];
      hrdata_ff <= (a_take && !hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cmd_ff  <= 16'h0000;
      wdat_ff <= 16'h0000;
    end else begin
      if (go_cmd) cmd_ff <= hwdata[15:0];
      if (a_wr_ff && a_addr_ff == HR_WDATA) wdat_ff <= hwdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b || !busy || tick) begin
      qcnt_ff <= 8'h00;
    end else begin
      qcnt_ff <= qcnt_ff + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff     <= M_IDLE;
      ph_ff     <= 2'h0;
      bi_ff     <= 2'h0;
      bt_ff     <= 4'h0;
      nack_ff   <= 1'b0;
      rdat_ff   <= 16'h0000;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (go_cmd) begin
      st_ff   <= M_START;
      ph_ff   <= 2'h0;
      nack_ff <= 1'b0;
      rdat_ff <= 16'h0000;
    end else if (tick) begin
      ph_ff <= ph_ff + 2'h1;
      case (st_ff)
        M_START: begin
          if (ph_ff == 2'h2) sda_oe_ff <= 1'b1;
          if (ph_ff == 2'h3) begin
            scl_oe_ff <= 1'b1;
            st_ff     <= M_BIT;
            bi_ff     <= 2'h0;
            bt_ff     <= 4'h0;
          end
        end
        M_BIT: begin
          case (ph_ff)
            2'h0: sda_oe_ff <= (bt_ff == 4'h8) ? (rx && !last) : (!rx && !tx_bit);
            2'h1: scl_oe_ff <= 1'b0;
            2'h2: begin
              if (bt_ff != 4'h8 && rx) rdat_ff <= {rdat_ff[14:0], lvl[1]};
              if (bt_ff == 4'h8 && !rx && lvl[1]) nack_ff <= 1'b1;
            end
            default: begin
              scl_oe_ff <= 1'b1;
              bt_ff     <= (bt_ff == 4'h8) ? 4'h0 : bt_ff + 4'h1;
              if (bt_ff == 4'h8 && (last || nack_ff)) st_ff <= M_STOP;
              if (bt_ff == 4'h8) bi_ff <= bi_ff + 2'h1;
            end
          endcase
        end
        M_STOP: begin
          if (ph_ff == 2'h0) sda_oe_ff <= 1'b1;
          if (ph_ff == 2'h1) scl_oe_ff <= 1'b0;
          if (ph_ff == 2'h2) sda_oe_ff <= 1'b0;
          if (ph_ff == 2'h3) st_ff <= M_IDLE;
        end
        default: begin
          st_ff     <= M_IDLE;
          scl_oe_ff <= 1'b0;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata       = hrdata_ff;
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_scl_oe = scl_oe_ff;
  assign bus.m_sda_oe = sda_oe_ff;
endmodule
`default_nettype wire

// file: bench/tss_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tss_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // A whole byte plus its acknowledge, with margin.
  localparam logic [13:0] OE_MAX = 14'h2710;
  logic [13:0] oe_cnt_ff;
  logic [13:0] nxt_oe_cnt;
  assign nxt_oe_cnt = s_sda_oe ? oe_cnt_ff + 14'h1 : 14'h0;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      oe_cnt_ff <= 14'h0;
    end else begin
      oe_cnt_ff <= nxt_oe_cnt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  low_only_a: assert property (s_sda_oe |-> !s_sda_o)
    else $error("sensor drives data high");
  rise_low_a: assert property ($rose(s_sda_oe) |-> !scl)
    else $error("sensor pulls data while clock high");
  stop_release_a: assert property (scl && $rose(sda) |-> !s_sda_oe [*8])
    else $error("sensor drives data after stop");
  start_quiet_a: assert property (scl && $fell(sda) |=> !s_sda_oe [*4])
    else $error("sensor drives data right after start");
  hold_high_a: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*8])
    else $error("sensor data not held over clock high");
  fall_hold_a: assert property ($fell(scl) |-> $stable(s_sda_oe) [*2])
    else $error("sensor data changed at clock fall");
  oe_bound_a: assert property (oe_cnt_ff <= OE_MAX)
    else $error("sensor holds data low too long");
  host_od_a: assert property (m_scl_oe || m_sda_oe |-> !m_scl_o && !m_sda_o)
    else $error("controller drives a line high");
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
  cover property ($rose(s_sda_oe));
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import tss_pkg::*;
;
  logic        mclk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [2:0]  sa;
  logic        conv_done;
  logic [12:0] temp_sample;
  logic        event_out;
  logic        shutdown;
  int          fails;
  int          n_compared;
  int          ta;
  int          up;
  logic [15:0] upw;
  logic [31:0] rd;
  int          exp_q[$];
  tss_if i_tss_if ();
  tss_slave #(.MAKER_CODE(16'h1234), .PART_CODE(16'h5678)) i_tss_slave (
    .mclk(mclk), .rst_b(rst_b), .bus(i_tss_if), .addr_select_hi(sa[2]),
    .addr_select_mid(sa[1]), .addr_select_lo(sa[0]), .conv_done(conv_done),
    .temp_sample(temp_sample), .event_out(event_out), .shutdown(shutdown));
  tss_host i_tss_host (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus(i_tss_if));
  tss_monitor i_tss_monitor (
    .mclk(mclk), .rst_b(rst_b), .m_scl_o(i_tss_if.m_scl_o), .m_scl_oe(i_tss_if.m_scl_oe),
    .m_sda_o(i_tss_if.m_sda_o), .m_sda_oe(i_tss_if.m_sda_oe), .s_sda_o(i_tss_if.s_sda_o),
    .s_sda_oe(i_tss_if.s_sda_oe), .scl(i_tss_if.scl), .sda(i_tss_if.sda));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo;
    fails++;
    $display("wrong value at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; entered right after a rising edge.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (hresp !== 1'b0) begin
      fails++;
      $display("wrong value at %0t: error response", $time);
    end
    r = hrdata;
    if (n >= 100) tmo();
  endtask
  task automatic run_cmd(input logic [1:0] md, input logic [2:0] s, input logic [3:0] p,
                         output logic [31:0] st);
    int k;
    ahb(1'b1, HR_CMD, {22'h0, md, 1'b0, s, p}, st);
    k = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && k < 10000) begin
      ahb(1'b0, HR_STAT, 32'h0, st);
      k++;
    end
    if (k >= 10000) tmo();
  endtask
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    conv_done = 1'b0;
    temp_sample = 13'h0;
    fails = 0;
    n_compared = 0;
    ta = $urandom(32'h8bef);
    sa = 3'($urandom);
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({30'h0, event_out, shutdown}, 32'h2);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h0);
    $display("reset and unmapped test done");
    upw = 16'($urandom) & LIM_MASK;
    up = $signed(upw[12:0]);
    ahb(1'b1, HR_WDATA, {16'h0, upw}, rd);
    run_cmd(MODE_WR, sa, PTR_UP, rd);
    chk({30'h0, rd[1:0]}, 32'h0);
    exp_q.push_back(int'(upw));
    run_cmd(MODE_RD, sa, 4'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h0);
    ahb(1'b0, HR_RDATA, 32'h0, rd);
    chk(rd, 32'(exp_q.pop_front()));
    $display("limit write test done");
    temp_sample <= 13'($urandom) & 13'h1ffc;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    run_cmd(MODE_PTR, sa, PTR_AMB, rd);
    chk({30'h0, rd[1:0]}, 32'h0);
    run_cmd(MODE_RD, sa, 4'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h0);
    ta = $signed(temp_sample);
    ahb(1'b0, HR_RDATA, 32'h0, rd);
    chk({16'h0, rd[15:0]}, {16'h0, ta >= 0, ta > up, ta < 0, temp_sample});
    $display("ambient read test done");
    exp_q.push_back(32'h1234);
    run_cmd(MODE_PTR, sa, PTR_MAKER, rd);
    chk({30'h0, rd[1:0]}, 32'h0);
    run_cmd(MODE_RD, sa, 4'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h0);
    ahb(1'b0, HR_RDATA, 32'h0, rd);
    chk(rd, 32'(exp_q.pop_front()));
    $display("identity read test done");
    run_cmd(MODE_RD, sa ^ 3'h4, 4'h0, rd);
    chk({30'h0, rd[1:0]}, 32'h2);
    $display("wrong address test done");
    complete_run();
  end
endmodule
`default_nettype wire
